// ---- rtl/pap_pkg.sv ----
`default_nettype none
package pap_pkg;
	// Timebase of the system clock
	localparam int CLK_PERIOD_PS = 4000;
	// Least spacing of data phases, in tenths of a system clock period
	localparam int SPACE_WR_LO_TENTHS = 15;
	localparam int SPACE_HI_TENTHS = 35;
	// Least spacing of low-range reads, in nanoseconds
	localparam int SPACE_RD_LO_NS = 30;
	// Derived cycle counts, least times rounded up
	localparam logic [3:0] CYC_WR_LO =
		4'((SPACE_WR_LO_TENTHS * CLK_PERIOD_PS + 10 * CLK_PERIOD_PS - 1) / (10 * CLK_PERIOD_PS));
	localparam logic [3:0] CYC_HI =
		4'((SPACE_HI_TENTHS * CLK_PERIOD_PS + 10 * CLK_PERIOD_PS - 1) / (10 * CLK_PERIOD_PS));
	localparam logic [3:0] CYC_RD_LO =
		4'((SPACE_RD_LO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// Register space landmarks
	localparam logic [7:0] ADDR_HI_BASE = 8'h80;
	localparam logic [7:0] ADDR_INDIRECT_BASE = 8'hC0;
	localparam logic [7:0] ADDR_INDIRECT_READOUT = 8'h88;
	// Value returned by the discarded first read of an indirect fetch
	localparam logic [7:0] DUMMY_READ_VALUE = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [3:0] BUSY_IDLE = 4'h0;
	// Access phase of the port
	typedef enum logic [1:0] {PH_IDLE, PH_STALL, PH_SERVED} pap_phase_type;
endpackage : pap_pkg
`default_nettype wire

// ---- rtl/pap_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pap_bus_if;
	logic mux;       // Multiplexed mode entered
	logic act;       // Combined strobe active
	logic act_start; // First active cycle
	logic act_end;   // First cycle after the strobe rose
	logic is_rd;     // Access direction is read
	logic is_addr;   // Address phase (non-multiplexed only)
	logic ale_rise;  // Latch strobe rising edge
	logic [7:0] wdata;    // Write data held from the strobe
	logic [7:0] pin_data; // Live bus for address latching
	modport dec (output mux, act, act_start, act_end, is_rd, is_addr, ale_rise, wdata, pin_data);
	modport core (input mux, act, act_start, act_end, is_rd, is_addr, ale_rise, wdata, pin_data);
endinterface : pap_bus_if
`default_nettype wire

// ---- rtl/pap_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module pap_decode (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Host pins
	input wire logic mode3_strap_i,
	input wire logic cs_n_i,
	input wire logic port_fetch_line_i,
	input wire logic port_store_line_i,
	input wire logic address_select_line_i,
	input wire logic ale_i,
	input wire logic [7:0] data_i,
	// Decoded access
	pap_bus_if.dec bus
);
	logic mode3_reg, mode3_next;         // Separate read/write strobes
	logic strap_done_reg, strap_done_next; // Strap taken after release
	logic mux_reg, mux_next;             // Multiplexed mode, sticky
	logic act_reg, act_next;             // Strobe seen last cycle
	logic ale_reg, ale_next;             // Latch strobe last cycle
	logic rd_reg, rd_next;               // Direction last cycle
	logic asel_reg, asel_next;           // Address select last cycle
	logic [7:0] wdata_reg, wdata_next;   // Bus sample during strobe
	logic rd_comb_n;
	logic wr_comb_n;
	logic act_now;
	logic rd_now;

	// Strobes combined with chip select, active only while both low
	always_comb
	begin
		rd_comb_n = port_fetch_line_i | cs_n_i;
		wr_comb_n = port_store_line_i | cs_n_i;
		// Mode 3 has two strobes, mode 2 one strobe plus direction
		act_now = mode3_reg ? (!rd_comb_n || !wr_comb_n) : !rd_comb_n;
		rd_now = mode3_reg ? !rd_comb_n : port_store_line_i;
		mode3_next = strap_done_reg ? mode3_reg : mode3_strap_i;
		strap_done_next = 1'b1;
		// Reset holds this flop, so edges during reset never count
		mux_next = mux_reg | (strap_done_reg & ale_i & !ale_reg);
		act_next = act_now;
		ale_next = ale_i;
		rd_next = act_now ? rd_now : rd_reg;
		asel_next = act_now ? address_select_line_i : asel_reg;
		// Keep the last sample taken under the strobe; it is written on its rise
		wdata_next = act_now ? data_i : wdata_reg;
	end

	// Registers
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode3_reg <= 1'b0;
			strap_done_reg <= 1'b0;
			mux_reg <= 1'b0;
			act_reg <= 1'b0;
			ale_reg <= 1'b0;
			rd_reg <= 1'b0;
			asel_reg <= 1'b0;
			wdata_reg <= pap_pkg::ADDR_RESET;
		end
		else if (ce_i)
		begin
			mode3_reg <= mode3_next;
			strap_done_reg <= strap_done_next;
			mux_reg <= mux_next;
			act_reg <= act_next;
			ale_reg <= ale_next;
			rd_reg <= rd_next;
			asel_reg <= asel_next;
			wdata_reg <= wdata_next;
		end
	end

	// Decoded view for the port logic
	assign bus.mux = mux_reg;
	assign bus.act = act_now;
	assign bus.act_start = act_now & !act_reg;
	assign bus.act_end = !act_now & act_reg;
	assign bus.is_rd = act_now ? rd_now : rd_reg;
	// Multiplexed modes ignore the select line entirely
	assign bus.is_addr = !mux_reg & (act_now ? address_select_line_i : asel_reg);
	assign bus.ale_rise = strap_done_reg & ale_i & !ale_reg;
	assign bus.wdata = wdata_reg;
	assign bus.pin_data = data_i;
endmodule : pap_decode
`default_nettype wire

// ---- rtl/pap_port.sv ----
// How it works
// - Select low data access, high address access
// - Selected address kept across data accesses
// - Latch strobe captures address from bus
// - First read of indirect registers (0xC0 and up) is dummy
// - Indirect readout register returns fetched value
// - Other registers read directly once
// - Address read-back returns selected address
// - Decode access from chip select and strobes
// - Effective strobe is strobe OR chip select
// - Drive read data during strobe, then release
// - Write data taken at strobe rising edge
// - Wait only when data phases too close
// - Spacing 1.5 or 3.5 clock periods, 30 ns for low-range reads
// - Multiplexed mode entered on first latch edge
`timescale 1ns/1ps
`default_nettype none
module pap_port (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Mode strap, high selects separate read/write strobes
	input wire logic mode3_strap_i,
	// Host bus pins
	input wire logic cs_n_i,
	input wire logic port_fetch_line_i,
	input wire logic port_store_line_i,
	input wire logic address_select_line_i,
	input wire logic ale_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Open-drain wait, pulled low while enabled
	output logic wait_o,
	output logic wait_oe_o,
	// Register space of the device
	output logic [7:0] core_addr_o,
	output logic [7:0] core_wdata_o,
	output logic core_wr_o,
	output logic core_rd_o,
	input wire logic [7:0] core_rdata_i
);
	pap_bus_if bus ();

	// Pin decoding and mode selection
	pap_decode u_decode (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.mode3_strap_i(mode3_strap_i),
		.cs_n_i(cs_n_i),
		.port_fetch_line_i(port_fetch_line_i),
		.port_store_line_i(port_store_line_i),
		.address_select_line_i(address_select_line_i),
		.ale_i(ale_i),
		.data_i(data_i),
		.bus(bus)
	);

	// Spacing a finished access needs before the next data phase
	function automatic logic [3:0] space_cycles(input logic [7:0] addr, input logic rd);
		if (addr >= pap_pkg::ADDR_HI_BASE)
			return pap_pkg::CYC_HI;
		return rd ? pap_pkg::CYC_RD_LO : pap_pkg::CYC_WR_LO;
	endfunction : space_cycles

	pap_pkg::pap_phase_type phase_reg, phase_next; // Access phase
	logic [7:0] addr_reg, addr_next;       // Selected register
	logic [7:0] dout_reg, dout_next;       // Read data on the bus
	logic [7:0] ind_reg, ind_next;         // Indirect readout value
	logic [7:0] wdat_reg, wdat_next;       // Data toward the core
	logic [3:0] busy_reg, busy_next;       // Cycles until internal access ends
	logic oe_reg, oe_next;
	logic wait_reg, wait_next;
	logic wr_reg, wr_next;
	logic rd_reg, rd_next;
	logic rd_fire;   // A read is served this cycle
	logic data_want; // A data phase wants service

	// Next values for the access sequencer
	always_comb
	begin
		phase_next = phase_reg;
		addr_next = addr_reg;
		dout_next = dout_reg;
		ind_next = ind_reg;
		wdat_next = wdat_reg;
		busy_next = (busy_reg != pap_pkg::BUSY_IDLE) ? busy_reg - 4'h1 : busy_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		rd_fire = 1'b0;
		data_want = bus.act && !bus.is_addr;
		// Capture core data the cycle its read strobe stands
		if (rd_reg)
		begin
			if (addr_reg >= pap_pkg::ADDR_INDIRECT_BASE)
				ind_next = core_rdata_i;
			else
				dout_next = core_rdata_i;
		end
		unique case (phase_reg)
			pap_pkg::PH_IDLE,
			pap_pkg::PH_STALL:
			begin
				if (bus.act)
				begin
					// A data phase inside the spacing window is stalled
					if (data_want && busy_reg != pap_pkg::BUSY_IDLE)
						phase_next = pap_pkg::PH_STALL;
					else
					begin
						phase_next = pap_pkg::PH_SERVED;
						rd_fire = bus.is_rd;
					end
				end
				else
					phase_next = pap_pkg::PH_IDLE;
			end
			pap_pkg::PH_SERVED:
			begin
				if (!bus.act)
					phase_next = pap_pkg::PH_IDLE;
			end
		endcase
		// Read service
		if (rd_fire)
		begin
			if (bus.is_addr)
				dout_next = addr_reg;
			else
			begin
				busy_next = space_cycles(addr_reg, 1'b1);
				if (addr_reg == pap_pkg::ADDR_INDIRECT_READOUT)
					dout_next = ind_reg;
				else
				begin
					rd_next = 1'b1;
					// Upper range answers a dummy and starts a fetch
					if (addr_reg >= pap_pkg::ADDR_INDIRECT_BASE)
						dout_next = pap_pkg::DUMMY_READ_VALUE;
				end
			end
		end
		// Writes take effect on the strobe's rising edge
		if (bus.act_end && !bus.is_rd && phase_reg != pap_pkg::PH_IDLE)
		begin
			if (bus.is_addr)
				addr_next = bus.wdata;
			else
			begin
				wr_next = 1'b1;
				wdat_next = bus.wdata;
				busy_next = space_cycles(addr_reg, 1'b0);
			end
		end
		// Address latch; the edge that enters multiplexed mode latches too
		// Data phases leave the address alone
		if (bus.ale_rise)
			addr_next = bus.pin_data;
		// Drive only while a read strobe is active
		oe_next = bus.act && bus.is_rd && phase_next == pap_pkg::PH_SERVED;
		// Wait pulled only while a data phase is stalled; busy bounds its length
		wait_next = data_want && phase_next == pap_pkg::PH_STALL;
	end

	// Registers of the sequencer
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			phase_reg <= pap_pkg::PH_IDLE;
			addr_reg <= pap_pkg::ADDR_RESET;
			dout_reg <= pap_pkg::ADDR_RESET;
			ind_reg <= pap_pkg::ADDR_RESET;
			wdat_reg <= pap_pkg::ADDR_RESET;
			busy_reg <= pap_pkg::BUSY_IDLE;
			oe_reg <= 1'b0;
			wait_reg <= 1'b0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			phase_reg <= phase_next;
			addr_reg <= addr_next;
			dout_reg <= dout_next;
			ind_reg <= ind_next;
			wdat_reg <= wdat_next;
			busy_reg <= busy_next;
			oe_reg <= oe_next;
			wait_reg <= wait_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// Outputs straight from flops, except wait_o tied low
	assign data_o = dout_reg;
	assign data_oe_o = oe_reg;
	assign wait_o = 1'b0;
	assign wait_oe_o = wait_reg;
	assign core_addr_o = addr_reg;
	assign core_wdata_o = wdat_reg;
	assign core_wr_o = wr_reg;
	assign core_rd_o = rd_reg;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_wait_needs_busy: assert property (ce_i && wait_next |-> busy_reg != pap_pkg::BUSY_IDLE)
		else $error("wait pulled with no access in progress");
	a_wait_release: assert property (ce_i && wait_reg && busy_reg == pap_pkg::BUSY_IDLE |=> !wait_oe_o)
		else $error("wait kept after internal access ended");
	a_oe_release: assert property (ce_i && !bus.act |=> !data_oe_o)
		else $error("bus driven without read strobe");
	a_addr_hold: assert property (ce_i && !bus.ale_rise && !(bus.act_end && bus.is_addr) |=> $stable(addr_reg))
		else $error("selected address changed by data access");
	a_dummy_read: assert property (ce_i && rd_fire && !bus.is_addr && addr_reg >= pap_pkg::ADDR_INDIRECT_BASE |=> data_o == pap_pkg::DUMMY_READ_VALUE ##0 core_rd_o)
		else $error("indirect first read not dummy");
	a_indirect_load: assert property (ce_i && core_rd_o && core_addr_o >= pap_pkg::ADDR_INDIRECT_BASE |=> ind_reg == $past(core_rdata_i))
		else $error("indirect readout not loaded");
	a_direct_read: assert property (ce_i && core_rd_o && core_addr_o < pap_pkg::ADDR_INDIRECT_BASE |=> data_o == $past(core_rdata_i))
		else $error("direct read value wrong");
	a_readback: assert property (ce_i && rd_fire && bus.is_addr |=> data_o == $past(addr_reg))
		else $error("address read-back wrong");
	a_write_edge: assert property (core_wr_o |-> $past(bus.act_end) && !$past(bus.is_addr))
		else $error("write not on strobe rise");
	a_write_space: assert property (core_wr_o && core_addr_o < pap_pkg::ADDR_HI_BASE |-> busy_reg == pap_pkg::CYC_WR_LO)
		else $error("low write spacing wrong");
	a_mux_sticky: assert property (bus.mux || (ce_i && bus.ale_rise) |=> bus.mux)
		else $error("multiplexed mode left");
endmodule : pap_port
`default_nettype wire

// ---- tb/pap_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pap_host_model (
	// Clock and strobe style
	input wire logic clk_i,
	input wire logic mode3_i,
	// Device drive of the shared bus
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_i,
	input wire logic wait_n_i,
	// Host pins
	output logic cs_n_o,
	output logic fetch_o,
	output logic store_o,
	output logic sel_o,
	output logic ale_o,
	output logic [7:0] bus_o
);
	logic drv = 1'b0; // Host owns the bus
	logic [7:0] dq = 8'h00; // Host bus value
	logic [7:0] last = 8'h00; // Bus value one cycle ago
	logic hang = 1'b0; // Wait held past its bound
	initial
	begin
		cs_n_o = 1'b1;
		fetch_o = 1'b1;
		store_o = 1'b1;
		sel_o = 1'b0;
		ale_o = 1'b0;
	end
	// No pull on the bus: a released bus toggles every cycle
	assign bus_o = drv ? dq : (dev_oe_i ? dev_data_i : ~last);
	always @(posedge clk_i) last <= bus_o;
	// One access: address or data phase, read or write
	task automatic xfer(input logic a, input logic rd, input logic cs, input logic [7:0] wd,
		output logic [7:0] rv);
		int n;
		n = 0;
		@(posedge clk_i);
		sel_o <= a;
		store_o <= mode3_i ? 1'b1 : rd; // Direction set up before strobe
		drv <= !rd;
		dq <= wd;
		@(posedge clk_i);
		cs_n_o <= !cs;
		fetch_o <= mode3_i ? !rd : 1'b0;
		if (mode3_i)
			store_o <= rd;
		repeat (3) @(posedge clk_i);
		// Stretch while wait is low, bounded
		while (!wait_n_i && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			hang = 1'b1;
		repeat (3) @(posedge clk_i);
		rv = bus_o;
		cs_n_o <= 1'b1;
		fetch_o <= 1'b1;
		store_o <= 1'b1;
		drv <= 1'b0;
		sel_o <= 1'b0; // Select rests low; multiplexed use ignores it
	endtask : xfer
	// Latch strobe pulse with an address on the bus
	task automatic latch(input logic [7:0] ad);
		@(posedge clk_i);
		drv <= 1'b1;
		dq <= ad;
		@(posedge clk_i);
		ale_o <= 1'b1;
		@(posedge clk_i);
		ale_o <= 1'b0;
		@(posedge clk_i);
		drv <= 1'b0;
	endtask : latch
endmodule : pap_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, ce, mode3, doe, wo, woe, cwr, crd, cs_n, fetch, store, sel, ale, saw_wait;
	logic [7:0] dout, caddr, cwd, crdata, bus, rv, wr_addr, wr_data, sv;
	int n_fail = 0;
	int samples_checked = 0;
	int n_wr = 0;
	int n_rd = 0;
	int n0;
	// Register space stand-in: contents derived from address
	assign crdata = caddr + 8'h3C;
	pap_port u_dut (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .mode3_strap_i(mode3),
		.cs_n_i(cs_n), .port_fetch_line_i(fetch), .port_store_line_i(store),
		.address_select_line_i(sel), .ale_i(ale), .data_i(bus), .data_o(dout), .data_oe_o(doe),
		.wait_o(wo), .wait_oe_o(woe), .core_addr_o(caddr), .core_wdata_o(cwd),
		.core_wr_o(cwr), .core_rd_o(crd), .core_rdata_i(crdata));
	// Open-drain wait with board pull-up
	pap_host_model u_host (.clk_i(clk), .mode3_i(mode3), .dev_data_i(dout), .dev_oe_i(doe),
		.wait_n_i(woe ? wo : 1'b1), .cs_n_o(cs_n), .fetch_o(fetch), .store_o(store),
		.sel_o(sel), .ale_o(ale), .bus_o(bus));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Core side monitor
	always @(posedge clk)
	begin
		if (cwr === 1'b1)
		begin
			n_wr++;
			wr_addr = caddr;
			wr_data = cwd;
		end
		if (crd === 1'b1)
			n_rd++;
		if (woe === 1'b1)
			saw_wait = 1'b1;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Access with hang cut-off
	task automatic acc(input logic a, input logic rd, input logic [7:0] wd, input logic cs = 1);
		u_host.xfer(a, rd, cs, wd, rv);
		if (u_host.hang)
		begin
			n_fail++;
			$display("[ERR] %0t wait never released", $time);
			tally_and_finish();
		end
	endtask : acc
	// Let a write land in the core and reach the monitor
	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle
	// Reset with a latch pulse inside it, which must be ignored
	task automatic do_reset(input logic m3);
		rst <= 1'b1;
		mode3 <= m3;
		u_host.latch(8'h77);
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_reset
	task automatic t_addr();
		acc(1, 0, 8'h10);
		settle();
		chk(caddr, 8'h10, "address write");
		acc(1, 1, 8'h00);
		chk(rv, 8'h10, "address read-back");
		$display("t_addr done");
	endtask : t_addr
	task automatic t_data();
		acc(0, 0, 8'hA5);
		settle();
		chk(wr_data, 8'hA5, "write data");
		chk(wr_addr, 8'h10, "write address");
		n0 = n_rd;
		acc(0, 1, 8'h00);
		chk(rv, 8'h4C, "first read");
		saw_wait = 1'b0;
		acc(0, 1, 8'h00);
		chk(rv, 8'h4C, "repeat read");
		chk(8'(n_rd - n0), 8'h02, "core read count");
		chk({7'h00, saw_wait}, 8'h01, "stall on close reads");
		$display("t_data done");
	endtask : t_data
	task automatic t_cs();
		n0 = n_wr;
		acc(0, 0, 8'h3C, 0);
		repeat (4) @(posedge clk);
		chk(8'(n_wr - n0), 8'h00, "deselected write");
		$display("t_cs done");
	endtask : t_cs
	task automatic t_ind();
		acc(1, 0, 8'hC5);
		n0 = n_rd;
		acc(0, 1, 8'h00);
		chk(rv, pap_pkg::DUMMY_READ_VALUE, "discarded read");
		chk(8'(n_rd - n0), 8'h01, "fetch issued");
		acc(1, 0, pap_pkg::ADDR_INDIRECT_READOUT);
		acc(0, 1, 8'h00);
		chk(rv, 8'h01, "readout value");
		$display("t_ind done");
	endtask : t_ind
	task automatic t_irq();
		acc(1, 1, 8'h00);
		sv = rv;
		acc(1, 0, 8'h20);
		acc(0, 0, 8'h5A);
		settle();
		chk(wr_addr, 8'h20, "service write");
		acc(1, 0, sv);
		acc(1, 1, 8'h00);
		chk(rv, pap_pkg::ADDR_INDIRECT_READOUT, "restored address");
		$display("t_irq done");
	endtask : t_irq
	task automatic t_gap();
		acc(1, 0, 8'h10);
		acc(0, 0, 8'h11);
		repeat (4) @(posedge clk);
		saw_wait = 1'b0;
		acc(0, 0, 8'h12);
		chk({7'h00, saw_wait}, 8'h00, "no stall when spaced");
		$display("t_gap done");
	endtask : t_gap
	task automatic t_mux();
		u_host.latch(8'h30);
		repeat (2) @(posedge clk);
		chk(caddr, 8'h30, "latched address");
		acc(0, 1, 8'h00);
		chk(rv, 8'h6C, "multiplexed read");
		acc(0, 0, 8'h99);
		settle();
		chk(wr_data, 8'h99, "multiplexed write");
		chk(wr_addr, 8'h30, "multiplexed address");
		$display("t_mux done");
	endtask : t_mux
	// Enable low freezes the port: an address write must not land
	task automatic t_ce();
		settle();
		ce <= 1'b0;
		acc(1, 0, 8'h55);
		settle();
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk(caddr, 8'h10, "frozen while enable low");
		$display("t_ce done");
	endtask : t_ce
	initial
	begin
		rst = 1'b1;
		mode3 = 1'b0;
		ce = 1'b1;
		saw_wait = 1'b0;
		do_reset(1'b0);
		t_addr();
		t_ce();
		t_data();
		t_cs();
		t_ind();
		t_irq();
		t_gap();
		t_mux();
		do_reset(1'b1);
		t_addr();
		t_data();
		t_ind();
		t_mux();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
